// ==== fpu_dispatch_ext_control.sv ====
/*
  floating-point dispatch, coprocessor detection, store of the control
  word and extension control register behind an avalon-mm slave.
  assumes instruction stream ports on clk and coprocessor pins async.
*/
// The Avalon-MM register port and the register offsets were left to the implementer.
// Summary of operation
// RULE1 - legacy enable, disable, notify opcodes do nothing
// RULE2 - split store may keep first half only
// RULE3 - fp instruction waits for previous to finish
// RULE4 - serializing op waits for all prior work
// RULE5 - sample coprocessor error after reset, before fp
// RULE6 - older part error inactive, newer part active
// RULE7 - reset or initialize never raises fp error
// RULE8 - stored control word ffff absent, 037f present
// RULE9 - trap flag clear passes, set traps fp
// RULE10 - monitor flag makes wait test task switched
// RULE11 - trap flag set raises vector seven trap
// RULE12 - software picks flag settings per coprocessor presence
// RULE13 - bit ten flags os simd fault support
// RULE14 - bit nine flags os extended state save
// RULE15 - bit five widens physical address to 36
// RULE16 - bit seven keeps global translations on switch
// RULE17 - bit eight allows perf counter read anywhere
// RULE18 - reset clears extension control to zero
// RULE19 - virtual-8086 flag enables virtual interrupt flag
// RULE20 - undefined bits read zero, writes act next
`timescale 1ns/10ps
module fpu_dispatch_ext_control (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        instr_valid,
  input  wire logic [3:0]  instr_op,
  input  wire logic [1:0]  instr_cpl,
  input  wire logic        instr_split_fault,
  output logic             instr_ready,
  output logic             trap_valid,
  output logic      [7:0]  trap_vector,
  output logic             fpu_start,
  input  wire logic        fpu_done,
  input  wire logic        coproc_error_n,
  input  wire logic        coproc_present_n,
  output logic             numeric_fault_report,
  output logic             mem_we,
  output logic      [7:0]  mem_data,
  output logic             mem_hi_byte,
  output logic             store_fault,
  input  wire logic [35:0] paddr_in,
  output logic      [35:0] paddr_out,
  input  wire logic        tlb_flush_req,
  input  wire logic        tlb_entry_global,
  output logic             tlb_flush_entry,
  input  wire logic        v86_mode,
  output logic             virt_if_enable,
  output logic             os_simd_fault_support,
  output logic             os_ext_state_save
);

  logic [31:0]                      ext_ctrl_q;
  logic [31:0]                      mach_ctrl_q;
  logic                             ack_q;
  logic                             busy_q;
  logic                             done_prev_q;
  logic                             fp_error_q;
  logic                             op_init_q;
  logic                             split_fault_q;
  logic [2:0]                       pin_s;
  logic                             detect_done;
  logic                             coproc_present;
  logic                             coproc_newer;
  logic                             accept;
  logic                             is_fp;
  logic                             need_idle_fpu;
  logic                             fp_trap_to_software;
  logic                             monitor_coproc_flag;
  logic                             task_switched_flag;
  logic                             phys_addr_widen;
  logic                             global_page_keep;
  logic                             perf_counter_read_allow;
  logic                             v86_extensions;
  logic                             bus_wr;
  logic [31:0]                      be_mask;
  logic [31:0]                      status_word;
  logic [15:0]                      cw_value;
  fpu_dispatch_pkg::disp_state_type state_q;

  // pin synchronizers: done, error active, present active
  pin_sync #(
    .WIDTH        (3)
  ) u_pin_sync (
    .clk          (clk),
    .reset_n      (reset_n),
    .pin_in       ({coproc_present_n, coproc_error_n, fpu_done}),
    .rst_val      (3'b110),
    .pin_sync_out (pin_s)
  );

  // newer part holds error active after reset, older inactive
  coproc_detect u_detect (
    .clk            (clk),
    .reset_n        (reset_n),
    .error_active   (pin_s[1]), // RULE6
    .present_active (pin_s[2]),
    .detect_done    (detect_done),
    .coproc_present (coproc_present),
    .coproc_newer   (coproc_newer)
  );

  // flag decode
  assign fp_trap_to_software = mach_ctrl_q[fpu_dispatch_pkg::TRAP_SW_BIT];
  assign monitor_coproc_flag = mach_ctrl_q[fpu_dispatch_pkg::MONITOR_BIT];
  assign task_switched_flag  = mach_ctrl_q[fpu_dispatch_pkg::TASK_SW_BIT];
  assign phys_addr_widen =
    ext_ctrl_q[fpu_dispatch_pkg::PHYS_WIDEN_BIT];
  assign global_page_keep =
    ext_ctrl_q[fpu_dispatch_pkg::GLOBAL_KEEP_BIT];
  assign perf_counter_read_allow =
    ext_ctrl_q[fpu_dispatch_pkg::PERF_ALLOW_BIT];
  assign v86_extensions = ext_ctrl_q[fpu_dispatch_pkg::V86_EXT_BIT];
  assign os_simd_fault_support =
    ext_ctrl_q[fpu_dispatch_pkg::SIMD_FAULT_BIT]; // RULE13
  assign os_ext_state_save =
    ext_ctrl_q[fpu_dispatch_pkg::EXT_SAVE_BIT]; // RULE14

  // extension effects
  assign paddr_out = phys_addr_widen ? paddr_in
                     : {4'h0, paddr_in[31:0]}; // RULE15
  assign tlb_flush_entry = tlb_flush_req
                           & ~(global_page_keep & tlb_entry_global); // RULE16
  assign virt_if_enable = v86_extensions & v86_mode; // RULE19
  assign numeric_fault_report =
    fp_error_q & mach_ctrl_q[fpu_dispatch_pkg::NUM_FAULT_BIT];

  // avalon-mm slave: one wait cycle, answer on the second
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign bus_wr          = avs_write & ack_q;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[fpu_dispatch_pkg::ST_DETECT_BIT]  = detect_done;
    status_word[fpu_dispatch_pkg::ST_PRESENT_BIT] = coproc_present;
    status_word[fpu_dispatch_pkg::ST_NEWER_BIT]   = coproc_newer;
    status_word[fpu_dispatch_pkg::ST_BUSY_BIT]    = busy_q;
    status_word[fpu_dispatch_pkg::ST_ERROR_BIT]   = fp_error_q;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (avs_read & ~ack_q)
      begin
        case (avs_address)
          fpu_dispatch_pkg::EXT_CTRL_OFS:
            avs_readdata <= ext_ctrl_q & fpu_dispatch_pkg::EXT_CTRL_MASK;
          fpu_dispatch_pkg::MACH_CTRL_OFS:
            avs_readdata <= mach_ctrl_q;
          fpu_dispatch_pkg::STATUS_OFS:
            avs_readdata <= status_word;
          default:
            avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // extension control: reset to zero, undefined bits held at zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ext_ctrl_q <= fpu_dispatch_pkg::EXT_CTRL_RESET; // RULE18
    end
    else if (bus_wr && avs_address == fpu_dispatch_pkg::EXT_CTRL_OFS)
    begin
      ext_ctrl_q <= ((ext_ctrl_q & ~be_mask) | (avs_writedata & be_mask))
                    & fpu_dispatch_pkg::EXT_CTRL_MASK; // RULE20
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mach_ctrl_q <= fpu_dispatch_pkg::MACH_CTRL_RESET;
    end
    else if (bus_wr && avs_address == fpu_dispatch_pkg::MACH_CTRL_OFS)
    begin
      mach_ctrl_q <= ((mach_ctrl_q & ~be_mask) | (avs_writedata & be_mask))
                     & fpu_dispatch_pkg::MACH_CTRL_MASK;
    end
  end

  // instruction acceptance
  always_comb
  begin
    is_fp = 1'b0;
    case (instr_op)
      fpu_dispatch_pkg::OP_FP_ARITH,
      fpu_dispatch_pkg::OP_FP_SYNC,
      fpu_dispatch_pkg::OP_FP_INIT,
      fpu_dispatch_pkg::OP_FP_STORE_CW: is_fp = 1'b1;
      default:                          is_fp = 1'b0;
    endcase
  end

  assign need_idle_fpu = is_fp
                         | (instr_op == fpu_dispatch_pkg::OP_SERIALIZE);
  assign instr_ready = (state_q == fpu_dispatch_pkg::ST_IDLE)
                       & ~(need_idle_fpu
                           & (busy_q | fpu_start)) // RULE3 RULE4
                       & ~(is_fp & ~detect_done); // RULE5
  assign accept   = instr_valid & instr_ready;
  assign cw_value = coproc_present ? fpu_dispatch_pkg::CW_PRESENT
                                   : fpu_dispatch_pkg::CW_ABSENT; // RULE8

  // dispatch: numeric unit start or trap; legacy ops fall through
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fpu_start   <= 1'b0;
      trap_valid  <= 1'b0;
      trap_vector <= 8'h00;
      op_init_q   <= 1'b0;
    end
    else
    begin
      fpu_start  <= 1'b0;
      trap_valid <= 1'b0;
      if (accept)
      begin
        case (instr_op)
          fpu_dispatch_pkg::OP_FP_ARITH,
          fpu_dispatch_pkg::OP_FP_INIT:
          begin
            if (fp_trap_to_software)
            begin
              trap_valid  <= 1'b1; // RULE9
              trap_vector <= fpu_dispatch_pkg::NO_FPU_VECTOR; // RULE11
            end
            else
            begin
              fpu_start <= 1'b1; // RULE9
              op_init_q <= (instr_op == fpu_dispatch_pkg::OP_FP_INIT);
            end
          end
          fpu_dispatch_pkg::OP_FP_STORE_CW:
          begin
            if (fp_trap_to_software)
            begin
              trap_valid  <= 1'b1;
              trap_vector <= fpu_dispatch_pkg::NO_FPU_VECTOR; // RULE11
            end
          end
          fpu_dispatch_pkg::OP_FP_SYNC:
          begin
            if (monitor_coproc_flag && task_switched_flag)
            begin
              trap_valid  <= 1'b1; // RULE10
              trap_vector <= fpu_dispatch_pkg::NO_FPU_VECTOR;
            end
          end
          fpu_dispatch_pkg::OP_READ_PERF:
          begin
            if (instr_cpl != 2'b00 && !perf_counter_read_allow)
            begin
              trap_valid  <= 1'b1; // RULE17
              trap_vector <= fpu_dispatch_pkg::PERF_DENY_VECTOR;
            end
          end
          default:
          begin
            trap_valid <= 1'b0; // RULE1
          end
        endcase
      end
    end
  end

  // numeric unit busy tracking and error capture
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_q      <= 1'b0;
      done_prev_q <= 1'b0;
      fp_error_q  <= 1'b0;
    end
    else
    begin
      done_prev_q <= pin_s[0];
      if (fpu_start)
      begin
        busy_q <= 1'b1;
      end
      else if (pin_s[0] && !done_prev_q)
      begin
        busy_q <= 1'b0;
        if (pin_s[1] && !op_init_q && detect_done)
        begin
          fp_error_q <= 1'b1;
        end
      end
      if (accept && instr_op == fpu_dispatch_pkg::OP_FP_INIT
          && !fp_trap_to_software)
      begin
        fp_error_q <= 1'b0; // RULE7
      end
    end
  end

  // control word store, low byte then high byte
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q       <= fpu_dispatch_pkg::ST_IDLE;
      split_fault_q <= 1'b0;
      mem_we        <= 1'b0;
      mem_data      <= 8'h00;
      mem_hi_byte   <= 1'b0;
      store_fault   <= 1'b0;
    end
    else
    begin
      mem_we      <= 1'b0;
      store_fault <= 1'b0;
      case (state_q)
        fpu_dispatch_pkg::ST_IDLE:
        begin
          if (accept && instr_op == fpu_dispatch_pkg::OP_FP_STORE_CW
              && !fp_trap_to_software)
          begin
            state_q       <= fpu_dispatch_pkg::ST_STORE_LO;
            split_fault_q <= instr_split_fault;
          end
        end
        fpu_dispatch_pkg::ST_STORE_LO:
        begin
          mem_we      <= 1'b1;
          mem_data    <= cw_value[7:0];
          mem_hi_byte <= 1'b0;
          state_q     <= fpu_dispatch_pkg::ST_STORE_HI;
        end
        fpu_dispatch_pkg::ST_STORE_HI:
        begin
          mem_we      <= ~split_fault_q; // RULE2
          store_fault <= split_fault_q;
          mem_data    <= cw_value[15:8];
          mem_hi_byte <= 1'b1;
          state_q     <= fpu_dispatch_pkg::ST_IDLE;
        end
        default:
        begin
          state_q <= fpu_dispatch_pkg::ST_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_no_fpu_trap;
    trap_valid && trap_vector == fpu_dispatch_pkg::NO_FPU_VECTOR;
  endsequence

  sequence s_accept_op(logic [3:0] op);
    accept && instr_op == op;
  endsequence

  AST_LEGACY_NOP: // RULE1
    assert property (s_accept_op(fpu_dispatch_pkg::OP_IRQ_DISABLE)
      |=> !trap_valid && !fpu_start && $stable(ext_ctrl_q)
          && $stable(mach_ctrl_q) && state_q == fpu_dispatch_pkg::ST_IDLE)
    else $error("legacy opcode changed state");
  AST_SPLIT_STORE: // RULE2
    assert property (state_q == fpu_dispatch_pkg::ST_STORE_HI
      && split_fault_q |=> !mem_we && store_fault)
    else $error("faulted second half written");
  AST_FP_WAITS: // RULE3
    assert property (accept && is_fp |-> !busy_q && !fpu_start)
    else $error("fp op accepted while previous busy");
  AST_SERIALIZE: // RULE4
    assert property (s_accept_op(fpu_dispatch_pkg::OP_SERIALIZE)
      |-> !busy_q && state_q == fpu_dispatch_pkg::ST_IDLE)
    else $error("serialize accepted with work pending");
  AST_DETECT_FIRST: // RULE5
    assert property (accept && is_fp |-> detect_done)
    else $error("fp op before detection");
  AST_INIT_NO_ERROR: // RULE7
    assert property (s_accept_op(fpu_dispatch_pkg::OP_FP_INIT)
      ##0 !fp_trap_to_software |=> !fp_error_q)
    else $error("initialize left fp error set");
  AST_CW_STORE: // RULE8
    assert property (state_q == fpu_dispatch_pkg::ST_STORE_LO
      |=> mem_we && !mem_hi_byte && mem_data == cw_value[7:0])
    else $error("control word low byte wrong");
  AST_EM_TRAP: // RULE11
    assert property (s_accept_op(fpu_dispatch_pkg::OP_FP_ARITH)
      ##0 fp_trap_to_software |=> s_no_fpu_trap ##0 !fpu_start)
    else $error("trap flag set without vector seven");
  AST_EM_PASS: // RULE9
    assert property (s_accept_op(fpu_dispatch_pkg::OP_FP_ARITH)
      ##0 !fp_trap_to_software |=> fpu_start && !trap_valid ##1 busy_q)
    else $error("fp op not passed to numeric unit");
  AST_MP_TS: // RULE10
    assert property (s_accept_op(fpu_dispatch_pkg::OP_FP_SYNC)
      ##0 (monitor_coproc_flag && task_switched_flag) |=> s_no_fpu_trap)
    else $error("wait ignored task switched");
  AST_PHYS_NARROW: // RULE15
    assert property (!phys_addr_widen |-> paddr_out[35:32] == 4'h0)
    else $error("upper address lines active when narrow");

endmodule

// ==== fpu_dispatch_pkg.sv ====
/*
  constants, register map and enumerations for the floating-point
  dispatch and extension control block.
  assumes a 25 MHz clock and a byte-addressed avalon-mm register port.
*/
package fpu_dispatch_pkg;

  // register byte offsets
  localparam logic [3:0]  EXT_CTRL_OFS      = 4'h0;
  localparam logic [3:0]  MACH_CTRL_OFS     = 4'h4;
  localparam logic [3:0]  STATUS_OFS        = 4'h8;

  // extension control field positions
  localparam int          V86_EXT_BIT       = 0;
  localparam int          PHYS_WIDEN_BIT    = 5;
  localparam int          GLOBAL_KEEP_BIT   = 7;
  localparam int          PERF_ALLOW_BIT    = 8;
  localparam int          EXT_SAVE_BIT      = 9;
  localparam int          SIMD_FAULT_BIT    = 10;
  localparam logic [31:0] EXT_CTRL_MASK     = 32'h0000_07a1;
  localparam logic [31:0] EXT_CTRL_RESET    = 32'h0000_0000;

  // machine control floating-point field positions
  localparam int          MONITOR_BIT       = 1;
  localparam int          TRAP_SW_BIT       = 2;
  localparam int          TASK_SW_BIT       = 3;
  localparam int          NUM_FAULT_BIT     = 5;
  localparam logic [31:0] MACH_CTRL_MASK    = 32'h0000_002e;
  localparam logic [31:0] MACH_CTRL_RESET   = 32'h0000_0000;

  // status field positions
  localparam int          ST_DETECT_BIT     = 0;
  localparam int          ST_PRESENT_BIT    = 1;
  localparam int          ST_NEWER_BIT      = 2;
  localparam int          ST_BUSY_BIT       = 3;
  localparam int          ST_ERROR_BIT      = 4;

  // control word images seen by a store after initialize
  localparam logic [15:0] CW_PRESENT        = 16'h037f;
  localparam logic [15:0] CW_ABSENT         = 16'hffff;

  // trap vectors
  localparam logic [7:0]  NO_FPU_VECTOR     = 8'h07;
  localparam logic [7:0]  PERF_DENY_VECTOR  = 8'h0d;

  // detection settle time after reset release
  localparam int          CLK_PERIOD_NS     = 40;
  localparam int          DETECT_TIME_NS    = 200;
  localparam int          DETECT_CYCLES     =
    (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    OP_INT_OTHER   = 4'h0,
    OP_FP_ARITH    = 4'h1,
    OP_FP_SYNC     = 4'h2,
    OP_FP_INIT     = 4'h3,
    OP_FP_STORE_CW = 4'h4,
    OP_IRQ_ENABLE  = 4'h5,
    OP_IRQ_DISABLE = 4'h6,
    OP_PM_NOTIFY   = 4'h7,
    OP_SERIALIZE   = 4'h8,
    OP_READ_PERF   = 4'h9
  } op_type;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_STORE_LO = 2'b01,
    ST_STORE_HI = 2'b10
  } disp_state_type;

endpackage

// ==== pin_sync.sv ====
/*
  two-flop synchronizer for a group of pin levels.
  assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] rst_val,
  output logic      [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          meta_q[i]       <= 1'b0;
          pin_sync_out[i] <= 1'b0;
        end
        else
        begin
          meta_q[i]       <= pin_in[i] ^ rst_val[i];
          pin_sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule

// ==== coproc_detect.sv ====
/*
  coprocessor detection after reset release.
  assumes synchronized error and presence levels on clk.
*/
`timescale 1ns/10ps
module coproc_detect #(
  parameter int CYCLES = fpu_dispatch_pkg::DETECT_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic error_active,
  input  wire logic present_active,
  output logic      detect_done,
  output logic      coproc_present,
  output logic      coproc_newer
);

  logic [7:0] count_q;

  // sample the error level once the settle time has passed
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_q        <= 8'h00;
      detect_done    <= 1'b0;
      coproc_present <= 1'b0;
      coproc_newer   <= 1'b0;
    end
    else if (!detect_done)
    begin
      if (count_q == 8'(CYCLES))
      begin
        detect_done    <= 1'b1;
        coproc_present <= present_active;
        coproc_newer   <= present_active & error_active; // RULE5
      end
      else
      begin
        count_q <= count_q + 8'h01;
      end
    end
  end

endmodule

// ==== coproc_model.sv ====
/*
  behavioural math coprocessor: presence strap, error pin, done pin.
  assumes fpu_start is a one-cycle pulse on clk.
*/
`timescale 1ns/10ps
module coproc_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic fpu_start,
  input  wire logic present,
  input  wire logic newer,
  input  wire logic slow,
  output logic      fpu_done,
  output logic      coproc_error_n,
  output logic      coproc_present_n
);
  logic [2:0] cnt_q;

  assign coproc_present_n = ~present;
  // newer part holds error active after reset, older part inactive
  assign coproc_error_n = ~(present & newer);

  // done rises a short or long time after each start
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q    <= 3'h0;
      fpu_done <= 1'b0;
    end
    else if (fpu_start)
    begin
      cnt_q    <= slow ? 3'h7 : 3'h2;
      fpu_done <= 1'b0;
    end
    else if (cnt_q != 3'h0)
    begin
      cnt_q    <= cnt_q - 3'h1;
      fpu_done <= (cnt_q == 3'h1);
    end
  end
endmodule

// ==== fpu_dispatch_ext_control_tb.sv ====
/*
  self-checking bench: register bus, dispatch rows, store, detection.
  assumes the coprocessor model on the far side of the dispatch port.
*/
`timescale 1ns/10ps
module fpu_dispatch_ext_control_tb;
  logic        clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0;
  logic        avs_write = 1'b0, instr_valid = 1'b0;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf, instr_op = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  logic        avs_waitrequest, instr_ready, trap_valid, fpu_start;
  logic [1:0]  instr_cpl = 2'h0;
  logic        instr_split_fault = 1'b0, fpu_done, coproc_error_n;
  logic [7:0]  trap_vector, mem_data;
  logic        coproc_present_n, numeric_fault_report, mem_we, mem_hi_byte;
  logic        store_fault, tlb_flush_entry, virt_if_enable;
  logic [35:0] paddr_in = 36'ha_5555_aaaa, paddr_out;
  logic        tlb_flush_req = 1'b1, tlb_entry_global = 1'b1;
  logic        v86_mode = 1'b1, os_simd_fault_support, os_ext_state_save;
  logic        present = 1'b1, newer = 1'b0, slow = 1'b0, busy = 1'b0;
  logic [15:0] cw;
  logic [31:0] r, e;
  logic [31:0] rows [13] = '{32'h0010_0000, 32'h0410_0007, 32'h0a20_0007,
    32'h0820_0000, 32'h0093_000d, 32'h1093_0000, 32'h0090_0000,
    32'h0050_0000, 32'h0060_0000, 32'h0070_0000, 32'h0080_0000,
    32'h0e10_0007, 32'h0210_0000};
  int          n_fail = 0, total_checks = 0, n_trap = 0, n_start = 0;
  int          n_we = 0, n_sf = 0, t, s;

  always #20 clk = ~clk;

  fpu_dispatch_ext_control dut (.clk, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .instr_valid, .instr_op, .instr_cpl,
    .instr_split_fault, .instr_ready, .trap_valid, .trap_vector, .fpu_start,
    .fpu_done, .coproc_error_n, .coproc_present_n, .numeric_fault_report,
    .mem_we, .mem_data, .mem_hi_byte, .store_fault, .paddr_in, .paddr_out,
    .tlb_flush_req, .tlb_entry_global, .tlb_flush_entry, .v86_mode,
    .virt_if_enable, .os_simd_fault_support, .os_ext_state_save);

  coproc_model partner (.clk, .reset_n, .fpu_start, .present, .newer,
    .slow, .fpu_done, .coproc_error_n, .coproc_present_n);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one avalon cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int   n;
    logic ok;
    n = 0;
    ok = 1'b0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge clk);
      ok = (avs_waitrequest === 1'b0);
      n++;
    end
    while (!ok && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (!ok)
      check(32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic issue(input logic [3:0] op, input logic sf, input int w);
    int   n;
    logic ok;
    n = 0;
    ok = 1'b0;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_split_fault <= sf;
    do
    begin
      @(posedge clk);
      ok = (instr_ready === 1'b1);
      n++;
    end
    while (!ok && n < 50);
    instr_valid <= 1'b0;
    if (!ok)
      check(32'h0000_0001, 32'h0000_0000);
    repeat (w) @(posedge clk);
  endtask

  task automatic restart();
    int n;
    reset_n <= 1'b0;
    instr_op <= 4'h1;
    busy = 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check({31'h0, instr_ready}, 32'h0);
    rd = 32'h0;
    for (n = 0; n < 30 && rd[0] !== 1'b1; n++)
      bus(1'b0, fpu_dispatch_pkg::STATUS_OFS, 32'h0);
  endtask

  // pulse counters and overlap watch
  always @(negedge clk)
  begin
    if (trap_valid === 1'b1)
      n_trap++;
    if (store_fault === 1'b1)
      n_sf++;
    if (mem_we === 1'b1)
      cw = mem_hi_byte ? {mem_data, cw[7:0]} : {cw[15:8], mem_data};
    if (mem_we === 1'b1)
      n_we++;
    if (instr_valid && instr_ready === 1'b1 && instr_op == 4'h8)
      check({31'h0, busy}, 32'h0);
    if (fpu_start === 1'b1)
      check({31'h0, busy}, 32'h0);
    if (fpu_start === 1'b1)
      n_start++;
    if (fpu_start === 1'b1)
      busy = 1'b1;
  end
  always @(posedge fpu_done) busy = 1'b0;

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    restart();
    check(rd[2:0], 3'b011);
    bus(1'b0, fpu_dispatch_pkg::EXT_CTRL_OFS, 32'h0);
    check(rd, fpu_dispatch_pkg::EXT_CTRL_RESET);
    bus(1'b1, fpu_dispatch_pkg::EXT_CTRL_OFS, 32'hffff_ffff);
    bus(1'b0, fpu_dispatch_pkg::EXT_CTRL_OFS, 32'h0);
    check(rd, 32'h0000_07a1);
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b0, 4'hc, 32'h0);
    check(rd, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      e = k ? 32'h0 : 32'h0000_07a1;
      bus(1'b1, fpu_dispatch_pkg::EXT_CTRL_OFS, e);
      @(negedge clk);
      check({paddr_out[35:32], tlb_flush_entry, virt_if_enable,
             os_simd_fault_support, os_ext_state_save},
            {e[5] ? 4'ha : 4'h0, !e[7], e[0], e[10], e[9]});
    end
    $display("register test done");
    foreach (rows[i])
    begin
      r = rows[i];
      bus(1'b1, fpu_dispatch_pkg::EXT_CTRL_OFS, {23'h0, r[28], 8'h00});
      bus(1'b1, fpu_dispatch_pkg::MACH_CTRL_OFS, {28'h0, r[27:24]});
      instr_cpl <= r[17:16];
      t = n_trap;
      s = n_start;
      issue(r[23:20], 1'b0, 12);
      check(n_trap - t, {31'h0, r[7:0] != 8'h00});
      if (r[7:0] != 8'h00)
        check({24'h0, trap_vector}, {24'h0, r[7:0]});
      if (r[23:20] != 4'h2)
        check(n_start - s, {31'h0, r[23:20] == 4'h1 && r[7:0] == 8'h00});
    end
    $display("dispatch rows done");
    bus(1'b1, fpu_dispatch_pkg::MACH_CTRL_OFS, 32'h0);
    cw = 16'h0000;
    issue(4'h4, 1'b0, 12);
    check({16'h0, cw}, {16'h0, fpu_dispatch_pkg::CW_PRESENT});
    cw = 16'h0000;
    t = n_we;
    s = n_sf;
    issue(4'h4, 1'b1, 12);
    check({8'(n_we - t), 8'(n_sf - s), cw}, 32'h0101_007f);
    slow = 1'b1;
    s = n_start;
    issue(4'h1, 1'b0, 0);
    issue(4'h1, 1'b0, 0);
    issue(4'h8, 1'b0, 12);
    check(n_start - s, 32'h2);
    $display("store and ordering done");
    present = 1'b0;
    restart();
    check(rd[1:0], 2'b01);
    issue(4'h4, 1'b0, 12);
    check({16'h0, cw}, {16'h0, fpu_dispatch_pkg::CW_ABSENT});
    bus(1'b1, fpu_dispatch_pkg::MACH_CTRL_OFS, 32'h0000_0024);
    t = n_trap;
    issue(4'h1, 1'b0, 12);
    check(n_trap - t, 32'h1);
    present = 1'b1;
    newer = 1'b1;
    restart();
    check(rd[2:0], 3'b111);
    bus(1'b1, fpu_dispatch_pkg::MACH_CTRL_OFS, 32'h0000_0022);
    issue(4'h3, 1'b0, 12);
    bus(1'b0, fpu_dispatch_pkg::STATUS_OFS, 32'h0);
    check({rd[4], numeric_fault_report}, 2'b00);
    $display("detection test done");
    report_and_stop();
  end
endmodule
